// >>> hw/wwdt_top.sv
`timescale 1ns/100ps
module wwdt_top import wwdt_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration straps
  input wire logic cfg_wdt_on,
  input wire logic [PS_W-1:0] postscaler_config,
  // Oscillator and power state
  input wire logic low_power_oscillator,
  input wire logic sleep_idle,
  // Events
  output logic device_reset_req,
  output logic wake_req,
  output logic irq
);

  // ****************************************
  // Counter path
  // ****************************************
  wwdt_cnt_if cnt();

  wwdt_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .osc_level(low_power_oscillator),
    .bus(cnt)
  );

  wwdt_count u_count (
    .pclk(pclk),
    .presetn(presetn),
    .bus(cnt)
  );

  logic cfg_loaded;
  logic next_cfg_loaded;
  logic cfg_on;
  logic next_cfg_on;
  logic [PS_W-1:0] postscaler_shadow;
  logic [PS_W-1:0] next_shadow;
  logic sw_on;
  logic next_sw_on;
  logic win_en;
  logic next_win_en;
  logic run_on;
  logic fault;
  logic wake_ev;
  wwdt_state_t state;
  wwdt_state_t next_state;
  logic [HOLD_W-1:0] hold_cnt;
  logic [HOLD_W-1:0] next_hold;

  // ****************************************
  // APB decode
  // ****************************************
  logic hit_ctrl;
  logic hit_alias;
  logic hit_stat;
  logic hit_mask;
  logic mapped;
  logic setup_rd;
  logic acc_wr;
  logic ctrl_wr;
  logic clr_req;
  logic [31:0] ctrl_old;
  logic [31:0] ctrl_new;

  always_comb begin
    hit_ctrl = paddr == OFS_CONTROL;
    hit_alias = hit_ctrl || paddr == OFS_CTRL_CLR
      || paddr == OFS_CTRL_SET || paddr == OFS_CTRL_INV;
    hit_stat = paddr == OFS_STATUS;
    hit_mask = paddr == OFS_MASK;
    mapped = hit_alias || hit_stat || hit_mask;
    setup_rd = psel && !penable && !pwrite;
    acc_wr = psel && penable && pwrite && mapped;
  end

  // Zero wait states: read data is loaded in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Aliases act on the software enable, never on the strap enable
  always_comb begin
    ctrl_old = CTRL_RESET;
    ctrl_old[BIT_ON] = sw_on;
    ctrl_old[BIT_WIN] = win_en;
    case (paddr)
      OFS_CTRL_CLR: ctrl_new = ctrl_old & ~pwdata;
      OFS_CTRL_SET: ctrl_new = ctrl_old | pwdata;
      OFS_CTRL_INV: ctrl_new = ctrl_old ^ pwdata;
      default: ctrl_new = pwdata;
    endcase
    ctrl_new = ctrl_new & CTRL_WMASK;
    ctrl_wr = acc_wr && hit_alias;
    clr_req = ctrl_wr && ctrl_new[BIT_CLR];
  end

  // ****************************************
  // Control register
  // ****************************************
  assign run_on = cfg_on || sw_on;

  // Straps are caught on the first edge after reset release
  always_comb begin
    next_cfg_loaded = 1'b1;
    next_cfg_on = cfg_loaded ? cfg_on : cfg_wdt_on;
    next_shadow = cfg_loaded ? postscaler_shadow
                             : postscaler_config;
    next_sw_on = sw_on;
    next_win_en = win_en;
    if (fault) begin
      // A watchdog reset returns software state to its reset value
      next_sw_on = CTRL_RESET[BIT_ON];
      next_win_en = CTRL_RESET[BIT_WIN];
    end else if (ctrl_wr) begin
      next_sw_on = ctrl_new[BIT_ON];
      next_win_en = ctrl_new[BIT_WIN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded <= 1'b0;
      cfg_on <= 1'b0;
      postscaler_shadow <= '0;
      sw_on <= CTRL_RESET[BIT_ON];
      win_en <= CTRL_RESET[BIT_WIN];
    end else begin
      cfg_loaded <= next_cfg_loaded;
      cfg_on <= next_cfg_on;
      postscaler_shadow <= next_shadow;
      sw_on <= next_sw_on;
      win_en <= next_win_en;
    end
  end

  assign cnt.run = run_on;
  assign cnt.restart = clr_req;
  assign cnt.win_en = win_en;
  assign cnt.ps = postscaler_shadow;

  // ****************************************
  // Fault sequencing
  // ****************************************
  always_comb begin
    wake_ev = cnt.timeout && sleep_idle;
    fault = state == WWDT_RUN && (cnt.early_clr
      || (cnt.timeout && !sleep_idle));
    next_state = state;
    next_hold = hold_cnt;
    case (state)
      WWDT_RUN: begin
        if (fault) begin
          next_state = WWDT_HOLD;
          next_hold = HOLD_W'(RST_PULSE_CYC - 1);
        end
      end
      WWDT_HOLD: begin
        if (hold_cnt == '0) begin
          next_state = WWDT_RUN;
        end else begin
          next_hold = hold_cnt - HOLD_W'(1);
        end
      end
      default: begin
        next_state = WWDT_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= WWDT_RUN;
      hold_cnt <= '0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold;
    end
  end

  assign device_reset_req = state == WWDT_HOLD;

  // ****************************************
  // Status, mask and interrupt
  // ****************************************
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] next_mask;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] stat_clr;
  logic next_wake;

  // Status survives the device reset request so software can read the cause
  always_comb begin
    events = '0;
    events[ST_TIMEOUT] = cnt.timeout && !sleep_idle;
    events[ST_WAKE] = wake_ev;
    events[ST_WINFAULT] = cnt.early_clr;
    stat_clr = (acc_wr && hit_stat) ? pwdata[ST_W-1:0] : '0;
    next_status = (status & ~stat_clr) | events;
    next_mask = (acc_wr && hit_mask) ? pwdata[ST_W-1:0] : mask;
    next_wake = wake_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STAT_RESET;
      mask <= MASK_RESET;
      wake_req <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      wake_req <= next_wake;
    end
  end

  assign irq = |(status & mask);

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rd_word;
  logic [31:0] next_prdata;

  always_comb begin
    rd_word = '0;
    if (hit_alias) begin
      rd_word[BIT_ON] = run_on;
      rd_word[PS_LSB +: PS_W] = postscaler_shadow;
      rd_word[BIT_WIN] = win_en;
    end else if (hit_stat) begin
      rd_word[ST_W-1:0] = status;
    end else if (hit_mask) begin
      rd_word[ST_W-1:0] = mask;
    end
    next_prdata = setup_rd ? rd_word : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_timeout_reset: assert property (
    cnt.timeout && !sleep_idle && state == WWDT_RUN
      |=> device_reset_req ##0 status[ST_TIMEOUT])
    else $error("time-out did not request a reset");

  a_reset_length: assert property (
    $rose(device_reset_req) |-> device_reset_req[*8]
      ##1 device_reset_req[*2] ##1 !device_reset_req)
    else $error("reset request has wrong length");

  a_sleep_wakes: assert property (
    cnt.timeout && sleep_idle && state == WWDT_RUN
      |=> wake_req && !device_reset_req && status[ST_WAKE])
    else $error("time-out in sleep did not wake");

  a_on_starts: assert property (
    ctrl_wr && hit_ctrl && pwdata[BIT_ON] && !fault |=> cnt.run)
    else $error("enable write did not start counting");

  a_strap_holds: assert property (
    cfg_loaded && cfg_on |-> cnt.run)
    else $error("strap enabled counter stopped");

  a_on_reads: assert property (
    setup_rd && hit_ctrl |=> prdata[BIT_ON] == $past(run_on))
    else $error("enable bit read wrong");

  a_shadow_read: assert property (
    cfg_loaded |-> postscaler_shadow == ($past(cfg_loaded)
      ? $past(postscaler_shadow) : $past(postscaler_config)))
    else $error("postscaler shadow read wrong");

  a_win_write: assert property (
    ctrl_wr && hit_ctrl && !fault |=> win_en == $past(pwdata[BIT_WIN]))
    else $error("window enable did not follow write");

  a_unimpl_zero: assert property (
    setup_rd && hit_alias |=> (prdata & ~CTRL_RMASK) == 32'h0000_0000)
    else $error("unimplemented control bits not zero");

  a_alias_set: assert property (
    acc_wr && paddr == OFS_CTRL_SET && pwdata[BIT_WIN] && !fault
      |=> win_en && sw_on == $past(sw_on || pwdata[BIT_ON]))
    else $error("set alias wrong");

  a_alias_clr: assert property (
    acc_wr && paddr == OFS_CTRL_CLR && !fault
      |=> win_en == $past(win_en && !pwdata[BIT_WIN]))
    else $error("clear alias wrong");

  a_fault_status: assert property (
    cnt.early_clr |=> status[ST_WINFAULT]
      && (irq || !mask[ST_WINFAULT]))
    else $error("window fault not recorded");

  c_timeout_reset: cover property (cnt.timeout && !sleep_idle);
  c_sleep_wake: cover property (wake_ev);
  c_window_fault: cover property (cnt.early_clr);
  c_alias_inv: cover property (acc_wr && paddr == OFS_CTRL_INV);
endmodule

// >>> hw/wwdt_pkg.sv
// Summary of operation
// - While running, count oscillator ticks; reset the device unless software clears it.
// - A postscaler value selects the time-out period, two to the power of it, with codes above 20 giving two to the 20.
// - A time-out during Sleep or Idle wakes the device instead of resetting it.
// - Enable bit 15 starts the counter; clearing it stops only a software start.
// - Enable bit reads one whenever the counter runs, by strap or by software.
// - Read-only postscaler shadow, bits 6 to 2, loaded from the strap after reset.
// - Bit 1 selects windowed operation when set; it resets to zero.
// - Writing one to bit 0 restarts the count; writing zero does nothing.
// - Bits 31 to 16 and 14 to 7 ignore writes and read as zero.
// - Clear, set and invert aliases at 0x4, 0x8, 0xC change only written ones.
package wwdt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFS_CONTROL = 12'h000;
  localparam logic [APB_AW-1:0] OFS_CTRL_CLR = 12'h004;
  localparam logic [APB_AW-1:0] OFS_CTRL_SET = 12'h008;
  localparam logic [APB_AW-1:0] OFS_CTRL_INV = 12'h00C;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h010;
  localparam logic [APB_AW-1:0] OFS_MASK = 12'h014;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int BIT_ON = 15;
  localparam int PS_LSB = 2;
  localparam int PS_W = 5;
  localparam int BIT_WIN = 1;
  localparam int BIT_CLR = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_8003;
  localparam logic [31:0] CTRL_RMASK = 32'h0000_807E;

  // ****************************************
  // Status and mask fields
  // ****************************************
  localparam int ST_TIMEOUT = 0;
  localparam int ST_WAKE = 1;
  localparam int ST_WINFAULT = 2;
  localparam int ST_W = 3;
  localparam logic [ST_W-1:0] STAT_RESET = 3'h0;
  localparam logic [ST_W-1:0] MASK_RESET = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int RST_PULSE_NS = 40;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W = $clog2(RST_PULSE_CYC + 1);
  localparam int PS_MAX = 20;
  localparam int CNT_W = PS_MAX + 1;
  localparam int WIN_SHIFT = 2;

  typedef enum logic {WWDT_RUN, WWDT_HOLD} wwdt_state_t;

  // Larger codes clamp so the counter cannot overflow
  function automatic logic [CNT_W-1:0] wwdt_period(
    input logic [PS_W-1:0] ps
  );
    logic [PS_W-1:0] p;
    p = (ps > PS_W'(PS_MAX)) ? PS_W'(PS_MAX) : ps;
    wwdt_period = CNT_W'(1) << p;
  endfunction

  // Restarts are allowed only in the last quarter of the period
  function automatic logic [CNT_W-1:0] wwdt_win_open(
    input logic [PS_W-1:0] ps
  );
    logic [CNT_W-1:0] per;
    per = wwdt_period(ps);
    wwdt_win_open = per - (per >> WIN_SHIFT);
  endfunction

endpackage

// >>> hw/wwdt_cnt_if.sv
`timescale 1ns/100ps
interface wwdt_cnt_if;
  import wwdt_pkg::*;
  logic tick;
  logic run;
  logic restart;
  logic win_en;
  logic [PS_W-1:0] ps;
  logic timeout;
  logic early_clr;
  modport src(output tick);
  modport ctl(output run, restart, win_en, ps,
              input tick, timeout, early_clr);
  modport cnt(input tick, run, restart, win_en, ps,
              output timeout, early_clr);
endinterface

// >>> hw/wwdt_tick.sv
`timescale 1ns/100ps
module wwdt_tick import wwdt_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Oscillator level, synchronous to pclk
  input wire logic osc_level,
  // Tick toward the counter
  wwdt_cnt_if.src bus
);
  logic osc_q;
  logic next_osc_q;
  logic tick_q;
  logic next_tick_q;

  always_comb begin
    next_osc_q = osc_level;
    next_tick_q = osc_level & ~osc_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Resets high so a level already high at release is no false tick
      osc_q <= 1'b1;
      tick_q <= 1'b0;
    end else begin
      osc_q <= next_osc_q;
      tick_q <= next_tick_q;
    end
  end

  assign bus.tick = tick_q;
endmodule

// >>> hw/wwdt_count.sv
`timescale 1ns/100ps
module wwdt_count import wwdt_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and events
  wwdt_cnt_if.cnt bus
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] per;
  logic timeout_q;
  logic next_timeout;
  logic early_q;
  logic next_early;

  // Restart outranks a tick, so timeout and early fault never coincide
  always_comb begin
    per = wwdt_period(bus.ps);
    next_count = count;
    next_timeout = 1'b0;
    next_early = 1'b0;
    if (!bus.run) begin
      next_count = '0;
    end else if (bus.restart) begin
      next_count = '0;
      next_early = bus.win_en && (count < wwdt_win_open(bus.ps));
    end else if (bus.tick) begin
      if (count >= per - CNT_W'(1)) begin
        next_count = '0;
        next_timeout = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      timeout_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      count <= next_count;
      timeout_q <= next_timeout;
      early_q <= next_early;
    end
  end

  assign bus.timeout = timeout_q;
  assign bus.early_clr = early_q;

  a_period_end: assert property (
    @(posedge pclk) disable iff (!presetn)
    timeout_q |-> $past(count) == $past(per) - CNT_W'(1))
    else $error("time-out not at end of period");

  a_restart_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus.run && bus.restart |=> count == '0 && !timeout_q)
    else $error("restart did not zero the count");

  a_early_fault: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus.run && bus.restart && bus.win_en
      && count < wwdt_win_open(bus.ps) |=> early_q)
    else $error("early restart not flagged");
endmodule

// >>> bench/test_windowed_watchdog_timer.sv
`timescale 1ns/100ps
module test_windowed_watchdog_timer import wwdt_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, cfg_wdt_on, sleep_idle;
  logic [PS_W-1:0] postscaler_config;
  logic low_power_oscillator, device_reset_req, wake_req, irq;
  logic osc_run, seen_rst;
  logic [1:0] div;
  logic [31:0] rd;
  logic er;
  int fail_count, comparisons;

  wwdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_wdt_on(cfg_wdt_on), .postscaler_config(postscaler_config),
    .low_power_oscillator(low_power_oscillator), .sleep_idle(sleep_idle),
    .device_reset_req(device_reset_req), .wake_req(wake_req), .irq(irq));

  // ****************************************
  // Clock, oscillator and reset watch
  // ****************************************
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  // Oscillator toggles every 4 cycles, one tick per 8 cycles
  always @(posedge pclk) begin
    div <= div + 2'd1;
    if (osc_run && div == 2'd3) begin
      low_power_oscillator <= ~low_power_oscillator;
    end
    if (device_reset_req === 1'b1) begin
      seen_rst <= 1'b1;
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test();
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at an access edge
  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                     input logic [31:0] d);
    // An idle edge before each setup keeps clear of a just-disabled counter
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic do_reset(input logic cfg, input logic [PS_W-1:0] ps);
    @(posedge pclk);
    presetn <= 0;
    cfg_wdt_on <= cfg;
    postscaler_config <= ps;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
  endtask

  // Waits a bounded number of cycles for a pulse, returns 1 if seen
  task automatic wait_hi(ref logic s, input int lim, output logic hit);
    hit = 0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge pclk);
      hit = (s === 1'b1);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "control reset");
    apb(1, OFS_CONTROL, 32'hFFFF_FFFE);
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_800A, "reserved or enable");
    apb(1, OFS_CTRL_CLR, 32'h0000_8002);
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "clear alias");
    apb(1, OFS_CTRL_SET, 32'h0000_0002);
    apb(0, OFS_CTRL_SET, 0);
    chk(rd, 32'h0000_000A, "set alias");
    apb(1, OFS_CTRL_INV, 32'h0000_0002);
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "invert alias");
    apb(1, 12'h018, 32'h0000_8002);
    chk({31'h0, er}, 32'h1, "unmapped no error");
    apb(0, 12'h018, 0);
    chk(rd, 32'h0, "unmapped read");
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "unmapped write leaked");
  endtask

  task automatic t_timeout();
    logic hit;
    int n;
    apb(1, OFS_STATUS, 32'h7);
    osc_run <= 1;
    apb(1, OFS_CTRL_SET, 32'h0000_8000);
    wait_hi(device_reset_req, 200, hit);
    chk({31'h0, hit}, 32'h1, "no time-out reset");
    n = 0;
    while (device_reset_req === 1'b1 && n < 50) begin
      n++;
      @(negedge pclk);
    end
    chk(32'(n), 32'(RST_PULSE_CYC), "reset pulse length");
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h1, "time-out status");
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "enable not dropped");
  endtask

  task automatic t_restart();
    seen_rst <= 0;
    apb(1, OFS_CTRL_SET, 32'h0000_8000);
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_8008, "enable read");
    for (int i = 0; i < 12; i++) begin
      repeat (12) @(posedge pclk);
      apb(1, OFS_CONTROL, 32'h0000_8001);
    end
    apb(1, OFS_CTRL_CLR, 32'h0000_8000);
    chk({31'h0, seen_rst}, 32'h0, "reset despite restart");
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "restart bit reads");
  endtask

  task automatic t_sleep();
    logic hit;
    seen_rst <= 0;
    apb(1, OFS_STATUS, 32'h7);
    apb(1, OFS_MASK, 32'h2);
    sleep_idle <= 1;
    apb(1, OFS_CTRL_SET, 32'h0000_8000);
    wait_hi(wake_req, 200, hit);
    chk({31'h0, hit}, 32'h1, "no wake");
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    apb(1, OFS_CTRL_CLR, 32'h0000_8000);
    chk({31'h0, seen_rst}, 32'h0, "reset in sleep");
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h2, "wake status");
    apb(1, OFS_MASK, 32'h0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1, OFS_MASK, 32'h2);
    apb(1, OFS_STATUS, 32'h2);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    sleep_idle <= 0;
  endtask

  task automatic t_window();
    logic hit;
    osc_run <= 0;
    apb(1, OFS_CONTROL, 32'h0000_8002);
    apb(1, OFS_CTRL_SET, 32'h0000_0001);
    wait_hi(device_reset_req, 10, hit);
    chk({31'h0, hit}, 32'h1, "early restart");
    repeat (12) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk(rd & 32'h4, 32'h4, "window fault status");
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_0008, "fault keeps window");
  endtask

  task automatic t_strap();
    do_reset(1, 5'd3);
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_800C, "strap enable");
    apb(1, OFS_CONTROL, 32'h0000_0000);
    apb(0, OFS_CONTROL, 0);
    chk(rd, 32'h0000_800C, "strap stopped");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    cfg_wdt_on = 0;
    postscaler_config = 5'd2;
    low_power_oscillator = 0;
    sleep_idle = 0;
    osc_run = 0;
    seen_rst = 0;
    div = '0;
    fail_count = 0;
    comparisons = 0;
    do_reset(0, 5'd2);
    t_regs();
    t_timeout();
    t_restart();
    t_sleep();
    t_window();
    t_strap();
    stop_test();
  end
endmodule
